// [hdl/vcr_guest_state.sv]
`include "vcr_map.svh"

// Summary of operation
// R1 - revision at 0, abort at 4, data at 8
// R2 - region at most four kilobytes, size parameter
// R3 - revision word read, never written by device
// R4 - load fails on revision mismatch
// R5 - software stores revision before use
// R6 - abort word never affects operation
// R7 - abort writes non-zero abort word; software may too
// R8 - remaining data in own layout
// R9 - software keeps region in cacheable memory
// R10 - entry loads guest fields, exit stores them
// R11 - exit loads host-state area
// R12 - six groups, exit information read-only
// R13 - control, debug, pointer fields natural width
// R14 - segments: selector, base, limit, rights
// R15 - legacy segment bases keep 64 bits
// R16 - rights low half, limit bits reserved
// R17 - rights encoding type, class, level, flags
// R18 - unusable bit faults outside long mode
// R19 - stack segment level equals current level
// R20 - table bases natural, limits 32 bits
// R21 - model register fields, optional ones gated
// R22 - 32-bit system-management base field
module vcr_guest_state #(
   parameter logic [31:0] OWN_REVISION = 32'h00000A5A, // arbitrary value
   parameter int REGION_BYTES = `VCR_REGION_MAX,
   parameter bit LONG_MODE = 1'b1,
   parameter bit HAS_PERF = 1'b1,
   parameter bit HAS_PAT = 1'b1,
   parameter bit HAS_EFER = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [12:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_q,
   input wire logic seg_use_valid,
   input wire logic [2:0] seg_use_idx,
   input wire logic long_mode_active,
   input wire logic [1:0] cur_priv_level,
   output logic busy_q,
   output logic current_valid_q,
   output logic load_fail_q,
   output logic [1:0] priv_level_q,
   output logic seg_fault_q,
   output logic xfer_done_q
);

   localparam int REGION_WORDS = REGION_BYTES / 4;

   // structure memory and processor state
   logic [31:0] region_mem [0:1023];
   logic [31:0] core_q [0:`VCR_FIELD_WORDS-1];

   vcr_pkg::vcr_state_t state_q;
   logic [6:0] idx_q;
   logic entry_fail_q;
   logic [31:0] exit_count_q;
   vcr_pkg::vcr_cmd_t cmd;
   vcr_pkg::vcr_status_t status;
   logic cmd_wr;
   logic idle;
   logic load_ok;
   logic enter_ok;
   logic leave_ok;
   logic abort_ok;
   logic in_region;
   logic [9:0] sw_word;
   logic sw_region_wr;
   logic [12:0] core_off;
   logic core_hit;
   logic [6:0] core_idx;
   logic [31:0] rd_d;
   logic [6:0] fault_word;
   logic last;

   // legal bits of one state word, per field
   function automatic logic [31:0] field_mask(input logic [6:0] idx);
      logic [31:0] ones;
      logic [31:0] wide;
      int i;
      int k;
      int s;
      ones = 32'hFFFFFFFF;
      wide = LONG_MODE ? ones : 32'h00000000;
      i = int'(idx);
      k = 0;
      s = 0;
      field_mask = ones;
      // R13 control, debug and pointer words
      if (i < `VCR_SEG_FIRST)
      begin
         field_mask = i[0] ? wide : ones;
      end
      else if (i < `VCR_TBL_FIRST)
      begin
         k = (i - `VCR_SEG_FIRST) % `VCR_SEG_WORDS;
         s = (i - `VCR_SEG_FIRST) / `VCR_SEG_WORDS;
         // R14 selector, base, limit, rights
         case (k)
            0: field_mask = `VCR_SEL_MASK;
            // R15 upper base kept on long cores
            2: field_mask = wide;
            // R16 R17 R18 rights layout
            4: field_mask = `VCR_AR_MASK | ((s == 0) ? `VCR_AR_LONG : 32'h00000000);
            default: field_mask = ones;
         endcase
      end
      else if (i < `VCR_MSR_FIRST)
      begin
         // R20 table base natural, limit full
         k = (i - `VCR_TBL_FIRST) % 3;
         field_mask = (k == 1) ? wide : ones;
      end
      else
      begin
         // R21 model register widths and presence
         case (i - `VCR_MSR_FIRST)
            4, 6: field_mask = wide;
            7, 8: field_mask = HAS_PERF ? ones : 32'h00000000;
            9, 10: field_mask = HAS_PAT ? ones : 32'h00000000;
            11, 12: field_mask = HAS_EFER ? ones : 32'h00000000;
            // R22 system-management base
            default: field_mask = ones;
         endcase
      end
   endfunction : field_mask

   // value stored for one field on exit
   function automatic logic [31:0] save_word(
      input logic [6:0] idx,
      input logic [31:0] v,
      input logic [1:0] lvl
   );
      logic [31:0] w;
      w = v & field_mask(idx);
      // R19 stack level follows current level
      if (idx == `VCR_SS_AR_WORD)
      begin
         w[`VCR_AR_LEVEL_LSB +: 2] = lvl;
      end
      save_word = w;
   endfunction : save_word

   // command decode
   assign cmd = vcr_pkg::vcr_cmd_t'(reg_wdata);
   assign cmd_wr = reg_wr && (reg_addr == `VCR_OFF_CMD);
   assign idle = (state_q == vcr_pkg::VCR_IDLE);
   assign load_ok = cmd_wr && idle && cmd.load;
   assign enter_ok = cmd_wr && idle && cmd.enter && current_valid_q;
   assign leave_ok = cmd_wr && idle && cmd.leave && current_valid_q;
   assign abort_ok = cmd_wr && idle && cmd.abort;
   assign last = (idx_q == 7'(`VCR_FIELD_WORDS - 1));

   // R2 region window bounded by size
   assign in_region = int'(reg_addr) < REGION_BYTES;
   assign sw_word = reg_addr[11:2];
   // R12 exit information not software writable
   assign sw_region_wr = reg_wr && in_region && idle
      && (sw_word != `VCR_EXIT_REASON_WORD)
      && (sw_word != `VCR_EXIT_COUNT_WORD);

   // processor state window
   assign core_off = reg_addr - `VCR_OFF_CORE;
   assign core_hit = (reg_addr >= `VCR_OFF_CORE) && (int'(core_off[12:2]) < `VCR_FIELD_WORDS);
   assign core_idx = core_off[8:2];
   assign fault_word = 7'(`VCR_SEG_FIRST + `VCR_SEG_WORDS * int'(seg_use_idx) + 4);

   // status image
   always_comb
   begin
      status = '0;
      status.current = current_valid_q;
      status.load_fail = load_fail_q;
      status.busy = busy_q;
      status.entry_fail = entry_fail_q;
      status.priv_level = priv_level_q;
   end

   // read decode, unmapped reads zero
   always_comb
   begin
      rd_d = 32'h00000000;
      if (in_region)
      begin
         rd_d = region_mem[sw_word];
      end
      else if (reg_addr == `VCR_OFF_STATUS)
      begin
         rd_d = status;
      end
      else if (core_hit)
      begin
         rd_d = core_q[core_idx];
      end
   end

   // read data valid one cycle after strobe
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata_q <= 32'h00000000;
      end
      else
      begin
         reg_rdata_q <= reg_rd ? rd_d : 32'h00000000;
      end
   end

   // structure memory writes
   always_ff @(posedge ref_clk)
   begin
      // R1 R5 R7 software owns header words
      if (sw_region_wr)
      begin
         region_mem[sw_word] <= reg_wdata;
      end
      // R10 guest fields saved on exit
      if (state_q == vcr_pkg::VCR_SAVE)
      begin
         region_mem[`VCR_GUEST_WORD + 10'(idx_q)] <= save_word(idx_q, core_q[idx_q], cur_priv_level);
      end
      // R7 abort leaves a non-zero mark
      if (abort_ok)
      begin
         region_mem[`VCR_ABORT_WORD] <= {16'h0000, cmd.arg[15:1], cmd.arg[0] | ~|cmd.arg[15:1]};
      end
      // R12 exit information filled by device
      if (leave_ok)
      begin
         region_mem[`VCR_EXIT_REASON_WORD] <= {16'h0000, cmd.arg};
         region_mem[`VCR_EXIT_COUNT_WORD] <= exit_count_q + 32'h00000001;
      end
   end

   // exit counter
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         exit_count_q <= 32'h00000000;
      end
      else if (leave_ok)
      begin
         exit_count_q <= exit_count_q + 32'h00000001;
      end
   end

   // R3 R4 revision check on load
   // R6 abort word never compared
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         current_valid_q <= 1'b0;
         load_fail_q <= 1'b0;
      end
      else if (load_ok)
      begin
         current_valid_q <= (region_mem[`VCR_REV_WORD] == OWN_REVISION);
         load_fail_q <= (region_mem[`VCR_REV_WORD] != OWN_REVISION);
      end
   end

   // entry refused without a current structure
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         entry_fail_q <= 1'b0;
      end
      else if (cmd_wr && idle && cmd.enter)
      begin
         entry_fail_q <= !current_valid_q;
      end
   end

   // transfer engine, one word per cycle
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= vcr_pkg::VCR_IDLE;
         idx_q <= 7'h00;
         busy_q <= 1'b0;
         xfer_done_q <= 1'b0;
      end
      else
      begin
         xfer_done_q <= 1'b0;
         case (state_q)
            vcr_pkg::VCR_IDLE:
            begin
               idx_q <= 7'h00;
               if (enter_ok)
               begin
                  state_q <= vcr_pkg::VCR_ENTRY;
                  busy_q <= 1'b1;
               end
               else if (leave_ok)
               begin
                  state_q <= vcr_pkg::VCR_SAVE;
                  busy_q <= 1'b1;
               end
            end
            vcr_pkg::VCR_ENTRY, vcr_pkg::VCR_HOST:
            begin
               idx_q <= last ? 7'h00 : idx_q + 7'h01;
               if (last)
               begin
                  state_q <= vcr_pkg::VCR_IDLE;
                  busy_q <= 1'b0;
                  xfer_done_q <= 1'b1;
               end
            end
            vcr_pkg::VCR_SAVE:
            begin
               idx_q <= last ? 7'h00 : idx_q + 7'h01;
               // R11 host image follows the save
               if (last)
               begin
                  state_q <= vcr_pkg::VCR_HOST;
               end
            end
            default:
            begin
               state_q <= vcr_pkg::VCR_IDLE;
               busy_q <= 1'b0;
            end
         endcase
      end
   end

   // processor state loads
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < `VCR_FIELD_WORDS; i++)
         begin
            core_q[i] <= 32'h00000000;
         end
      end
      else if (state_q == vcr_pkg::VCR_ENTRY)
      begin
         // R8 R10 guest image into processor
         core_q[idx_q] <= region_mem[`VCR_GUEST_WORD + 10'(idx_q)] & field_mask(idx_q);
      end
      else if (state_q == vcr_pkg::VCR_HOST)
      begin
         // R11 host image into processor
         core_q[idx_q] <= region_mem[`VCR_HOST_WORD + 10'(idx_q)] & field_mask(idx_q);
      end
      else if (reg_wr && core_hit && idle)
      begin
         core_q[core_idx] <= reg_wdata & field_mask(core_idx);
      end
   end

   // R19 current level from stack rights
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         priv_level_q <= 2'h0;
      end
      else
      begin
         priv_level_q <= core_q[`VCR_SS_AR_WORD][`VCR_AR_LEVEL_LSB +: 2];
      end
   end

   // R18 unusable segment faults outside long mode
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         seg_fault_q <= 1'b0;
      end
      else
      begin
         seg_fault_q <= seg_use_valid && core_q[fault_word][`VCR_AR_UNUSABLE] && !long_mode_active;
      end
   end

endmodule : vcr_guest_state

// [hdl/vcr_map.svh]
`ifndef VCR_MAP_SVH
`define VCR_MAP_SVH
// header words of the region, byte addresses
`define VCR_OFF_REVISION 13'h0000
`define VCR_OFF_ABORT 13'h0004
`define VCR_OFF_DATA 13'h0008
`define VCR_REGION_MAX 4096
// control window above the region
`define VCR_OFF_CMD 13'h1000
`define VCR_OFF_STATUS 13'h1004
`define VCR_OFF_CORE 13'h1100
// word layout of the structure data
`define VCR_REV_WORD 10'h000
`define VCR_ABORT_WORD 10'h001
`define VCR_GUEST_WORD 10'h002
`define VCR_HOST_WORD 10'h04C
`define VCR_EXIT_REASON_WORD 10'h096
`define VCR_EXIT_COUNT_WORD 10'h097
`define VCR_FIELD_WORDS 74
// field groups inside one state image
`define VCR_SEG_FIRST 14
`define VCR_SEG_WORDS 5
`define VCR_TBL_FIRST 54
`define VCR_MSR_FIRST 60
`define VCR_SYSMGMT_WORD 73
`define VCR_SS_AR_WORD 7'h17
// access-rights layout
`define VCR_AR_MASK 32'h0001D0FF
`define VCR_AR_LONG 32'h00002000
`define VCR_AR_LEVEL_LSB 5
`define VCR_AR_UNUSABLE 16
`define VCR_SEL_MASK 32'h0000FFFF
`endif

// [hdl/vcr_pkg.sv]
package vcr_pkg;

   // transfer engine states, one-hot
   typedef enum logic [3:0] {
      VCR_IDLE = 4'h1,
      VCR_ENTRY = 4'h2,
      VCR_SAVE = 4'h4,
      VCR_HOST = 4'h8
   } vcr_state_t;

   // command word written to the command register
   typedef struct packed {
      logic [15:0] arg;
      logic [11:0] rsvd;
      logic abort;
      logic leave;
      logic enter;
      logic load;
   } vcr_cmd_t;

   // status word read back
   typedef struct packed {
      logic [25:0] rsvd;
      logic [1:0] priv_level;
      logic entry_fail;
      logic busy;
      logic load_fail;
      logic current;
   } vcr_status_t;

endpackage : vcr_pkg

// [sim/vcr_guest_state_props.sv]
module vcr_guest_state_props #(
   parameter logic [31:0] OWN_REVISION = 32'h00000A5A
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [12:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata_q,
   input wire logic seg_use_valid,
   input wire logic [2:0] seg_use_idx,
   input wire logic long_mode_active,
   input wire logic [1:0] cur_priv_level,
   input wire logic busy_q,
   input wire logic current_valid_q,
   input wire logic load_fail_q,
   input wire logic [1:0] priv_level_q,
   input wire logic seg_fault_q,
   input wire logic xfer_done_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic cmd_w;
   logic rev_ok_q;
   logic [7:0] busy_cnt_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // command register write strobe
   assign cmd_w = reg_wr && reg_addr == 13'h1000;
   // length of the running transfer
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         busy_cnt_q <= 8'h00;
      else if (busy_q)
         busy_cnt_q <= busy_cnt_q + 8'h01;
      else
         busy_cnt_q <= 8'h00;
   end
   // does the stored revision word match
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         rev_ok_q <= 1'b0;
      else if (reg_wr && reg_addr == 13'h0000 && !busy_q)
         rev_ok_q <= reg_wdata == OWN_REVISION;
   end
   a_load_result:
      assert property (cmd_w && reg_wdata[0] && !busy_q |=> current_valid_q == rev_ok_q && load_fail_q == !rev_ok_q)
      else $error("load result does not follow revision word");
   a_xfer_start:
      assert property (cmd_w && reg_wdata[2:0] != 3'h0 && !reg_wdata[0] && reg_wdata[2:1] != 2'h0
         && current_valid_q && !busy_q |=> busy_q [*8])
      else $error("transfer did not start");
   a_busy_cause:
      assert property ($rose(busy_q) |-> $past(cmd_w) && $past(reg_wdata[2:1]) != 2'h0)
      else $error("busy without command");
   a_xfer_length:
      assert property (xfer_done_q |-> busy_cnt_q == 8'h4A || busy_cnt_q == 8'h94)
      else $error("transfer length wrong");
   a_done_pulse:
      assert property ($fell(busy_q) |-> xfer_done_q ##1 !xfer_done_q)
      else $error("done pulse wrong");
   a_fault_cause:
      assert property (seg_fault_q |-> $past(seg_use_valid) && !$past(long_mode_active))
      else $error("segment fault without cause");
   a_status_read:
      assert property (reg_rd && reg_addr == 13'h1004 |=> reg_rdata_q[2:0] == {$past(busy_q), $past(load_fail_q),
         $past(current_valid_q)})
      else $error("status word wrong");
   a_abort_inert:
      assert property (reg_wr && (reg_addr == 13'h0004 || reg_addr == 13'h1000 && reg_wdata[3:0] == 4'h8)
         |=> $stable(current_valid_q) && $stable(load_fail_q))
      else $error("abort word changed operation");
   a_level_steady:
      assert property (!$past(busy_q, 2) && !$past(reg_wr, 2) |-> $stable(priv_level_q))
      else $error("current level moved while idle");
   c_entry: cover property (xfer_done_q && busy_cnt_q == 8'h4A);
   c_exit: cover property (xfer_done_q && busy_cnt_q == 8'h94);
   c_fault: cover property (seg_fault_q);
endmodule : vcr_guest_state_props

bind vcr_guest_state vcr_guest_state_props #(.OWN_REVISION(OWN_REVISION)) vcr_guest_state_props_i (
   .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .seg_use_valid(seg_use_valid), .seg_use_idx(seg_use_idx),
   .long_mode_active(long_mode_active), .cur_priv_level(cur_priv_level), .busy_q(busy_q),
   .current_valid_q(current_valid_q), .load_fail_q(load_fail_q), .priv_level_q(priv_level_q), .seg_fault_q(seg_fault_q),
   .xfer_done_q(xfer_done_q));

// [sim/vcr_guest_state_tb_top.sv]
module vcr_guest_state_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] REV = 32'h00000A5A; // arbitrary value
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [12:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata_q;
   logic seg_use_valid = 1'b0;
   logic [2:0] seg_use_idx = 3'h0;
   logic long_mode_active = 1'b0;
   logic [1:0] cur_priv_level = 2'h0;
   logic busy_q, current_valid_q, load_fail_q, seg_fault_q, xfer_done_q;
   logic [1:0] priv_level_q;
   int err_count = 0;
   int n_checks = 0;
   // 50 MHz clock
   always #10 ref_clk = ~ref_clk;
   vcr_hv_model vcr_hv_model_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
   vcr_guest_state #(.OWN_REVISION(REV), .REGION_BYTES(2048)) vcr_guest_state_i (.ref_clk(ref_clk),
      .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .seg_use_valid(seg_use_valid), .seg_use_idx(seg_use_idx),
      .long_mode_active(long_mode_active), .cur_priv_level(cur_priv_level), .busy_q(busy_q),
      .current_valid_q(current_valid_q), .load_fail_q(load_fail_q), .priv_level_q(priv_level_q),
      .seg_fault_q(seg_fault_q),
      .xfer_done_q(xfer_done_q));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic rc(input string name, input logic [12:0] a, input logic [31:0] exp);
      logic [31:0] d;
      vcr_hv_model_i.rd(a, d);
      chk(name, exp, d);
   endtask : rc
   // wait for the end of a transfer, bounded
   task automatic wait_done;
      for (int k = 0; k < 400 && xfer_done_q !== 1'b1; k++)
      begin
         @(posedge ref_clk);
         #1;
      end
      chk("xfer_done", 32'h1, {31'h0, xfer_done_q});
   endtask : wait_done
   // use the code segment once, watch for a fault
   task automatic seg_try(input logic lm, input logic exp);
      @(posedge ref_clk);
      seg_use_valid <= 1'b1;
      long_mode_active <= lm;
      @(posedge ref_clk);
      seg_use_valid <= 1'b0;
      #1;
      chk("seg_fault", {31'h0, exp}, {31'h0, seg_fault_q});
   endtask : seg_try
   // core word after masking an all-ones guest image
   function automatic logic [31:0] core_mask(input int i);
      if (i >= 14 && i < 54 && (i - 14) % 5 == 0)
         return 32'h0000FFFF;
      if (i >= 14 && i < 54 && (i - 14) % 5 == 4)
         return (i == 18) ? 32'h0001F0FF : 32'h0001D0FF;
      return 32'hFFFFFFFF;
   endfunction : core_mask
   // main sequence
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      rc("core_reset", 13'h1100, 32'h0);
      vcr_hv_model_i.prep(~REV);
      vcr_hv_model_i.wr(13'h1000, 32'h2);
      rc("status_refused", 13'h1004, 32'hA);
      vcr_hv_model_i.prep(REV);
      rc("status_loaded", 13'h1004, 32'h9);
      $display("test load done");
      for (int i = 2; i < 150; i++)
         vcr_hv_model_i.wr(13'(i * 4), (i < 76) ? 32'hFFFFFFFF : 32'h0);
      vcr_hv_model_i.wr(13'h1000, 32'h2);
      wait_done();
      for (int i = 0; i < 74; i++)
         rc("core_word", 13'h1100 + 13'(i * 4), core_mask(i));
      rc("status_entered", 13'h1004, 32'h31);
      rc("revision", 13'h0000, REV);
      $display("test entry done");
      seg_try(1'b0, 1'b1);
      seg_try(1'b1, 1'b0);
      cur_priv_level <= 2'h2;
      vcr_hv_model_i.wr(13'h1000, 32'h00300004);
      wait_done();
      vcr_hv_model_i.wr(13'h0258, 32'hFFFF);
      rc("exit_reason", 13'h0258, 32'h30);
      rc("exit_count", 13'h025C, 32'h1);
      rc("ss_rights", 13'h0064, 32'h0001D0DF);
      rc("cs_selector", 13'h0040, 32'h0000FFFF);
      rc("host_core", 13'h1100, 32'h0);
      chk("priv_level", 32'h0, {30'h0, priv_level_q});
      $display("test exit done");
      vcr_hv_model_i.wr(13'h1000, 32'h8);
      rc("abort_word", 13'h0004, 32'h1);
      vcr_hv_model_i.wr(13'h0004, 32'h5);
      rc("abort_sw", 13'h0004, 32'h5);
      rc("status_abort", 13'h1004, 32'h1);
      vcr_hv_model_i.wr(13'h0900, 32'h1234);
      rc("beyond_region", 13'h0900, 32'h0);
      rc("unmapped", 13'h1FFC, 32'h0);
      $display("test abort and range done");
      stop_test();
   end
   // watchdog
   initial
   begin
      #200us;
      err_count++;
      $display("FAIL watchdog expected finish seen hang");
      stop_test();
   end
endmodule : vcr_guest_state_tb_top

// [sim/vcr_hv_model.sv]
module vcr_hv_model (
   input wire logic ref_clk,
   output logic [12:0] reg_addr,
   output logic [31:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [31:0] reg_rdata_q
);
   timeunit 1ns;
   timeprecision 1ps;
   // bus idle at time zero
   initial
   begin
      reg_addr = 13'h0000;
      reg_wdata = 32'h00000000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // one write, data scrambled once released
   task automatic wr(input logic [12:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr
   // one read, data taken in the following cycle
   task automatic rd(input logic [12:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata_q;
   endtask : rd
   task automatic prep(input logic [31:0] rev);
      wr(13'h0000, rev);
      wr(13'h1000, 32'h00000001);
   endtask : prep
endmodule : vcr_hv_model
